// ===== design/osr_map.svh
// register width, field positions and reset values of the operation status group
`ifndef OSR_MAP_SVH
`define OSR_MAP_SVH

// width of every register in the group
`define OSR_REG_W 16

// condition bit positions, weight two to the position
`define OSR_BIT_SELFTEST 12
`define OSR_BIT_CFGMEM 10
`define OSR_BIT_OUT_OV 9
`define OSR_BIT_IN_OV 8
`define OSR_BIT_AUTO_COMP 7

// mask of condition bits that carry a function
`define OSR_COND_USED_MASK 16'h1780

// reset values
`define OSR_EVENT_RESET 16'h0000
`define OSR_ENABLE_RESET 16'h0000
`define OSR_COND_RESET 16'h0000
`define OSR_PTR_RESET 16'hFFFF
`define OSR_NTR_RESET 16'h0000

`endif

// ===== design/osr_pkg.sv
// types shared by the operation status group and its users
package osr_pkg;

  // host status commands and queries
  typedef enum logic [3:0] {
    OSR_Q_CONDITION,
    OSR_Q_EVENT,
    OSR_C_ENABLE,
    OSR_Q_ENABLE,
    OSR_C_PTR,
    OSR_Q_PTR,
    OSR_C_NTR,
    OSR_Q_NTR,
    OSR_C_CLEAR_STATUS
  } osr_op_t;

  // one command from the host
  typedef struct packed {
    logic valid;
    osr_op_t op;
    logic [15:0] wdata;
  } osr_cmd_t;

  // one query answer to the host
  typedef struct packed {
    logic valid;
    logic [15:0] data;
  } osr_rsp_t;

  // live instrument states, asynchronous to mclk
  typedef struct packed {
    logic selftest_active;
    logic config_mem_busy;
    logic output_overvoltage;
    logic input_overvoltage;
    logic auto_compensation_busy;
  } osr_state_t;

endpackage

// ===== design/osr_status_group.sv
// operation status group: condition, transition filters, event latch, enable, summary
`timescale 1ns/1ps
`include "osr_map.svh"

module osr_status_group #(
  parameter int REG_W = `OSR_REG_W
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire osr_pkg::osr_state_t state_in,
  input wire osr_pkg::osr_cmd_t cmd,
  output osr_pkg::osr_rsp_t rsp,
  output logic [REG_W-1:0] operation_condition,
  output logic operation_summary
);

  // true for commands that expect an answer
  function automatic logic is_query(input osr_pkg::osr_op_t op);
    is_query = (op == osr_pkg::OSR_Q_CONDITION) || (op == osr_pkg::OSR_Q_EVENT) ||
               (op == osr_pkg::OSR_Q_ENABLE) || (op == osr_pkg::OSR_Q_PTR) ||
               (op == osr_pkg::OSR_Q_NTR);
  endfunction

  // true when a valid command of the given kind is present
  function automatic logic cmd_is(input osr_pkg::osr_cmd_t c, input osr_pkg::osr_op_t op);
    cmd_is = c.valid && (c.op == op);
  endfunction

  osr_pkg::osr_state_t sync1_q;
  osr_pkg::osr_state_t sync2_q;
  logic [REG_W-1:0] cond_d;
  logic [REG_W-1:0] cond_q;
  logic [REG_W-1:0] ptr_q;
  logic [REG_W-1:0] ntr_q;
  logic [REG_W-1:0] en_q;
  logic [REG_W-1:0] ev_d;
  logic [REG_W-1:0] ev_q;
  logic [REG_W-1:0] rise;
  logic [REG_W-1:0] fall;
  logic [REG_W-1:0] new_ev;
  logic ev_clear;
  logic summary_q;
  osr_pkg::osr_rsp_t rsp_q;

  // two-stage synchroniser; the states come from other clock domains
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      sync1_q <= '0;
      sync2_q <= '0;
    end else begin
      sync1_q <= state_in;
      sync2_q <= sync1_q;
    end
  end

  // condition word assembly; unused positions tied low
  always_comb begin
    cond_d = `OSR_COND_RESET;
    cond_d[`OSR_BIT_SELFTEST] = sync2_q.selftest_active;
    cond_d[`OSR_BIT_CFGMEM] = sync2_q.config_mem_busy;
    cond_d[`OSR_BIT_OUT_OV] = sync2_q.output_overvoltage;
    cond_d[`OSR_BIT_IN_OV] = sync2_q.input_overvoltage;
    cond_d[`OSR_BIT_AUTO_COMP] = sync2_q.auto_compensation_busy;
  end

  // condition follows live state every cycle, reads never touch it
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      cond_q <= `OSR_COND_RESET;
    end else begin
      cond_q <= cond_d;
    end
  end

  // transition filter registers
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      ptr_q <= `OSR_PTR_RESET;
      ntr_q <= `OSR_NTR_RESET;
    end else begin
      if (cmd_is(cmd, osr_pkg::OSR_C_PTR)) begin
        ptr_q <= cmd.wdata;
      end
      if (cmd_is(cmd, osr_pkg::OSR_C_NTR)) begin
        ntr_q <= cmd.wdata;
      end
    end
  end

  // enable mask; only a host write changes it, clear-status leaves it alone
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      en_q <= `OSR_ENABLE_RESET;
    end else if (cmd_is(cmd, osr_pkg::OSR_C_ENABLE)) begin
      en_q <= cmd.wdata;
    end
  end

  // edge detection against the word that is about to be loaded
  assign rise = cond_d & ~cond_q;
  assign fall = ~cond_d & cond_q;
  assign new_ev = (rise & ptr_q) | (fall & ntr_q);
  assign ev_clear = cmd_is(cmd, osr_pkg::OSR_Q_EVENT) ||
                    cmd_is(cmd, osr_pkg::OSR_C_CLEAR_STATUS);

  // new events win over a clear in the same cycle so none are lost
  always_comb begin
    ev_d = ev_clear ? `OSR_EVENT_RESET : ev_q;
    ev_d = ev_d | new_ev;
  end

  // event latch
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      ev_q <= `OSR_EVENT_RESET;
    end else begin
      ev_q <= ev_d;
    end
  end

  // summary bit of the status byte, one cycle behind the latch
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      summary_q <= 1'b0;
    end else begin
      summary_q <= |(ev_q & en_q);
    end
  end

  // query answers: binary word whose value is the weight sum
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      rsp_q <= '0;
    end else begin
      rsp_q.valid <= cmd.valid && is_query(cmd.op);
      if (cmd.valid) begin
        unique case (cmd.op)
          osr_pkg::OSR_Q_CONDITION: rsp_q.data <= cond_q;
          osr_pkg::OSR_Q_EVENT: rsp_q.data <= ev_q;
          osr_pkg::OSR_Q_ENABLE: rsp_q.data <= en_q;
          osr_pkg::OSR_Q_PTR: rsp_q.data <= ptr_q;
          osr_pkg::OSR_Q_NTR: rsp_q.data <= ntr_q;
          default: rsp_q.data <= rsp_q.data; // writes and clear keep the last answer
        endcase
      end
    end
  end

  // outputs straight from flops
  assign rsp = rsp_q;
  assign operation_condition = cond_q;
  assign operation_summary = summary_q;

  // checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);

  // reset seen at the last three edges; the synchroniser refills after any reset
  logic [2:0] rst_hist_q;
  always_ff @(posedge mclk) begin
    rst_hist_q <= {rst_hist_q[1:0], sys_rst};
  end

  // pin to condition latency is three edges
  property p_selftest;
    rst_hist_q == 3'h0 |-> cond_q[`OSR_BIT_SELFTEST] == $past(state_in.selftest_active, 3);
  endproperty
  a_selftest: assert property (p_selftest)
    else $error("self-test condition bit wrong");

  property p_cfgmem;
    rst_hist_q == 3'h0 |-> cond_q[`OSR_BIT_CFGMEM] == $past(state_in.config_mem_busy, 3);
  endproperty
  a_cfgmem: assert property (p_cfgmem)
    else $error("config memory condition bit wrong");

  property p_overvolt;
    rst_hist_q == 3'h0 |->
      (cond_q[`OSR_BIT_OUT_OV] == $past(state_in.output_overvoltage, 3)) &&
      (cond_q[`OSR_BIT_IN_OV] == $past(state_in.input_overvoltage, 3));
  endproperty
  a_overvolt: assert property (p_overvolt)
    else $error("overvoltage condition bits wrong");

  property p_autocomp;
    rst_hist_q == 3'h0 |->
      cond_q[`OSR_BIT_AUTO_COMP] == $past(state_in.auto_compensation_busy, 3);
  endproperty
  a_autocomp: assert property (p_autocomp)
    else $error("auto compensation condition bit wrong");

  property p_unused_zero;
    (operation_condition & ~`OSR_COND_USED_MASK) == 16'h0000;
  endproperty
  a_unused_zero: assert property (p_unused_zero)
    else $error("unused condition bit set");

  property p_cond_read;
    cmd_is(cmd, osr_pkg::OSR_Q_CONDITION) |=> rsp.valid && rsp.data == $past(cond_q);
  endproperty
  a_cond_read: assert property (p_cond_read)
    else $error("condition query answer wrong");

  property p_rise_latch;
    ((cond_q & ~$past(cond_q) & $past(ptr_q)) & ~ev_q) == 16'h0000;
  endproperty
  a_rise_latch: assert property (p_rise_latch)
    else $error("filtered rise not latched");

  property p_fall_latch;
    ((~cond_q & $past(cond_q) & $past(ntr_q)) & ~ev_q) == 16'h0000;
  endproperty
  a_fall_latch: assert property (p_fall_latch)
    else $error("filtered fall not latched");

  property p_no_filter;
    (ev_q & ~$past(ev_q) & ~$past(ptr_q | ntr_q)) == 16'h0000;
  endproperty
  a_no_filter: assert property (p_no_filter)
    else $error("event set with both filters clear");

  property p_ptr_write;
    cmd_is(cmd, osr_pkg::OSR_C_PTR) ##1 cmd_is(cmd, osr_pkg::OSR_Q_PTR)
      |=> rsp.valid && rsp.data == $past(cmd.wdata, 2);
  endproperty
  a_ptr_write: assert property (p_ptr_write)
    else $error("positive filter read back wrong");

  property p_event_read;
    cmd_is(cmd, osr_pkg::OSR_Q_EVENT) |=>
      rsp.valid && rsp.data == $past(ev_q) && ev_q == $past(new_ev);
  endproperty
  a_event_read: assert property (p_event_read)
    else $error("event query did not answer and clear");

  property p_clear_status;
    cmd_is(cmd, osr_pkg::OSR_C_CLEAR_STATUS) |=> ev_q == $past(new_ev) && $stable(en_q);
  endproperty
  a_clear_status: assert property (p_clear_status)
    else $error("clear-status handled wrong");

  property p_reset_clear;
    disable iff (1'b0) sys_rst |=> ev_q == 16'h0000 && en_q == 16'h0000;
  endproperty
  a_reset_clear: assert property (p_reset_clear)
    else $error("reset left event or enable set");

  property p_enable_hold;
    !$past(cmd_is(cmd, osr_pkg::OSR_C_ENABLE)) |-> $stable(en_q);
  endproperty
  a_enable_hold: assert property (p_enable_hold)
    else $error("enable changed without a write");

  property p_summary;
    operation_summary == $past(|(ev_q & en_q));
  endproperty
  a_summary: assert property (p_summary)
    else $error("summary does not follow enabled events");

  property p_summary_clear;
    ((ev_q & en_q) == 16'h0000) [*2] |-> !operation_summary;
  endproperty
  a_summary_clear: assert property (p_summary_clear)
    else $error("summary stayed set with no enabled event");

  property p_sticky;
    !$past(ev_clear) |-> ($past(ev_q) & ~ev_q) == 16'h0000;
  endproperty
  a_sticky: assert property (p_sticky)
    else $error("event bit dropped without a clear");

  property p_ptr_land;
    cmd_is(cmd, osr_pkg::OSR_C_PTR) |=> ptr_q == $past(cmd.wdata);
  endproperty
  a_ptr_land: assert property (p_ptr_land)
    else $error("positive filter write lost");

  property p_ntr_land;
    cmd_is(cmd, osr_pkg::OSR_C_NTR) |=> ntr_q == $past(cmd.wdata);
  endproperty
  a_ntr_land: assert property (p_ntr_land)
    else $error("negative filter write lost");

  property p_ptr_read;
    cmd_is(cmd, osr_pkg::OSR_Q_PTR) |=> rsp.valid && rsp.data == $past(ptr_q);
  endproperty
  a_ptr_read: assert property (p_ptr_read)
    else $error("positive filter query answer wrong");

  property p_ntr_read;
    cmd_is(cmd, osr_pkg::OSR_Q_NTR) |=> rsp.valid && rsp.data == $past(ntr_q);
  endproperty
  a_ntr_read: assert property (p_ntr_read)
    else $error("negative filter query answer wrong");

  property p_enable_write;
    cmd_is(cmd, osr_pkg::OSR_C_ENABLE) |=> en_q == $past(cmd.wdata);
  endproperty
  a_enable_write: assert property (p_enable_write)
    else $error("enable write lost");

  property p_enable_read;
    cmd_is(cmd, osr_pkg::OSR_Q_ENABLE) |=> rsp.valid && rsp.data == $past(en_q);
  endproperty
  a_enable_read: assert property (p_enable_read)
    else $error("enable query answer wrong");

  property p_write_silent;
    cmd.valid && !is_query(cmd.op) |=> !rsp.valid;
  endproperty
  a_write_silent: assert property (p_write_silent)
    else $error("write or clear gave an answer");

  property p_clear_keeps_filters;
    cmd_is(cmd, osr_pkg::OSR_C_CLEAR_STATUS) |=> $stable(ptr_q) && $stable(ntr_q);
  endproperty
  a_clear_keeps_filters: assert property (p_clear_keeps_filters)
    else $error("clear-status changed a filter");

  c_rise_event: cover property ($rose(|ev_q));
  c_summary_up: cover property ($rose(operation_summary));
  c_read_clear: cover property (cmd_is(cmd, osr_pkg::OSR_Q_EVENT) && (ev_q != 16'h0000));
  c_set_beats_clear: cover property (ev_clear && (new_ev != 16'h0000));
  c_write_then_read: cover property (cmd_is(cmd, osr_pkg::OSR_C_PTR) ##1 cmd_is(cmd, osr_pkg::OSR_Q_PTR));

endmodule

// ===== verif/osr_host_model.sv
// host side model issuing status commands and collecting query answers
`timescale 1ns/1ps
module osr_host_model (
  input wire logic mclk,
  output osr_pkg::osr_cmd_t cmd,
  input wire osr_pkg::osr_rsp_t rsp
);
  initial cmd = '0;

  // one command per call, valid for a single cycle, answer sampled one cycle on
  task automatic send(input osr_pkg::osr_op_t op, input logic [15:0] wdata,
      output logic [15:0] rdata, output logic got);
    @(negedge mclk);
    cmd <= '{valid: 1'b1, op: op, wdata: wdata};
    @(negedge mclk);
    got = rsp.valid;
    rdata = rsp.data;
    // stale data inverted so a late capture cannot look right
    cmd <= '{valid: 1'b0, op: op, wdata: ~wdata};
  endtask

  // write and query in consecutive cycles, answer of the query sampled
  task automatic send2(input osr_pkg::osr_op_t wop, input logic [15:0] wdata,
      input osr_pkg::osr_op_t rop, output logic [15:0] rdata, output logic got);
    @(negedge mclk);
    cmd <= '{valid: 1'b1, op: wop, wdata: wdata};
    @(negedge mclk);
    cmd <= '{valid: 1'b1, op: rop, wdata: ~wdata};
    @(negedge mclk);
    got = rsp.valid;
    rdata = rsp.data;
    cmd <= '{valid: 1'b0, op: rop, wdata: wdata};
  endtask
endmodule

// ===== verif/osr_status_group_tb.sv
// self-checking bench of the operation status group
`timescale 1ns/1ps
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin errors++; \
  $display("CHECK FAILED %s expected %h seen %h", nm, e, g); end end

module osr_status_group_tb;
  logic mclk;
  logic sys_rst;
  osr_pkg::osr_state_t state_in;
  osr_pkg::osr_state_t st;
  osr_pkg::osr_cmd_t cmd;
  osr_pkg::osr_rsp_t rsp;
  logic [15:0] cond_w;
  logic summary_w;
  logic [15:0] ptr, ntr, en, ev, prev, nxt;
  int errors;
  int tests_run;

  osr_status_group uut (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .state_in(state_in),
    .cmd(cmd),
    .rsp(rsp),
    .operation_condition(cond_w),
    .operation_summary(summary_w)
  );

  osr_host_model host (
    .mclk(mclk),
    .cmd(cmd),
    .rsp(rsp)
  );

  // expected condition word from the live states
  function automatic logic [15:0] cond_of(input osr_pkg::osr_state_t s);
    cond_of = {3'h0, s.selftest_active, 1'b0, s.config_mem_busy, s.output_overvoltage,
      s.input_overvoltage, s.auto_compensation_busy, 7'h00};
  endfunction

  // query and compare the answer
  task automatic q(input string nm, input osr_pkg::osr_op_t op, input logic [15:0] e);
    logic [15:0] rd;
    logic got;
    host.send(op, 16'h0000, rd, got);
    `CHK(nm, 1'b1, got)
    `CHK(nm, e, rd)
  endtask

  // write then read back in the very next cycle
  task automatic wq(input string nm, input osr_pkg::osr_op_t wop, input osr_pkg::osr_op_t rop,
      input logic [15:0] v);
    logic [15:0] rd;
    logic got;
    host.send2(wop, v, rop, rd, got);
    `CHK(nm, 1'b1, got)
    `CHK(nm, v, rd)
  endtask

  // write or clear, which must give no answer
  task automatic w(input osr_pkg::osr_op_t op, input logic [15:0] v);
    logic [15:0] rd;
    logic got;
    host.send(op, v, rd, got);
    `CHK("no answer", 1'b0, got)
  endtask

  task complete_run;
    $display("errors %0d tests_run %0d", errors, tests_run);
    if (errors == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // free running clock
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  // watchdog, well above the longest sequence
  initial begin
    #500000;
    errors++;
    complete_run;
  end

  // main sequence: reset values, then random filter, enable and state rounds
  initial begin
    sys_rst = 1'b1;
    state_in = '0;
    errors = 0;
    tests_run = 0;
    void'($urandom(32'h0000_0093));
    repeat (2) @(posedge mclk);
    @(negedge mclk);
    sys_rst = 1'b0;
    `CHK("cond", 16'h0000, cond_w)
    `CHK("summary", 1'b0, summary_w)
    q("event", osr_pkg::OSR_Q_EVENT, 16'h0000);
    q("enable", osr_pkg::OSR_Q_ENABLE, 16'h0000);
    q("ptr", osr_pkg::OSR_Q_PTR, 16'hFFFF);
    q("ntr", osr_pkg::OSR_Q_NTR, 16'h0000);
    ev = '0;
    prev = '0;
    for (int i = 0; i < 40; i++) begin
      // first round: all states rise with both filters cleared
      ptr = (i == 0) ? 16'h0000 : 16'($urandom);
      ntr = (i == 0) ? 16'h0000 : 16'($urandom);
      en = (i == 0) ? 16'hFFFF : 16'($urandom);
      st = (i == 0) ? 5'h1F : 5'($urandom);
      wq("ptr", osr_pkg::OSR_C_PTR, osr_pkg::OSR_Q_PTR, ptr);
      w(osr_pkg::OSR_C_NTR, ntr);
      w(osr_pkg::OSR_C_ENABLE, en);
      q("ptr", osr_pkg::OSR_Q_PTR, ptr);
      q("ntr", osr_pkg::OSR_Q_NTR, ntr);
      nxt = cond_of(st);
      ev = ev | (ptr & ~prev & nxt) | (ntr & prev & ~nxt);
      prev = nxt;
      state_in = st;
      repeat (6) @(negedge mclk);
      `CHK("cond", nxt, cond_w)
      q("cond", osr_pkg::OSR_Q_CONDITION, nxt);
      q("cond", osr_pkg::OSR_Q_CONDITION, nxt);
      `CHK("summary", |(ev & en), summary_w)
      case (i % 3)
        0: begin
          q("event", osr_pkg::OSR_Q_EVENT, ev);
          ev = '0;
          q("event", osr_pkg::OSR_Q_EVENT, 16'h0000);
        end
        1: begin
          w(osr_pkg::OSR_C_CLEAR_STATUS, 16'($urandom));
          ev = '0;
          q("event", osr_pkg::OSR_Q_EVENT, 16'h0000);
          q("enable", osr_pkg::OSR_Q_ENABLE, en);
        end
        default: begin
          // events left pending to build up over the next round
        end
      endcase
    end
    // second reset in mid-run with enable loaded and falls pending
    w(osr_pkg::OSR_C_ENABLE, 16'h1780);
    state_in = '0;
    repeat (6) @(negedge mclk);
    sys_rst = 1'b1;
    repeat (2) @(posedge mclk);
    @(negedge mclk);
    sys_rst = 1'b0;
    `CHK("summary", 1'b0, summary_w)
    q("event", osr_pkg::OSR_Q_EVENT, 16'h0000);
    q("enable", osr_pkg::OSR_Q_ENABLE, 16'h0000);
    q("ptr", osr_pkg::OSR_Q_PTR, 16'hFFFF);
    q("ntr", osr_pkg::OSR_Q_NTR, 16'h0000);
    w(osr_pkg::OSR_C_ENABLE, 16'h1780);
    q("enable", osr_pkg::OSR_Q_ENABLE, 16'h1780);
    w(osr_pkg::OSR_C_ENABLE, 16'h0000);
    q("enable", osr_pkg::OSR_Q_ENABLE, 16'h0000);
    complete_run;
  end
endmodule
